// file: design/pmc_pkg.sv
// Package for the power mode control register block.
// Assumes a 32-bit Avalon-MM slave with waitrequest and one 100 MHz clock.
// ----------------------------------------------------------------------------
// Constants and types
// ----------------------------------------------------------------------------
package pmc_pkg;
  // Printed offsets are not all multiples of four, so they are indices.
  localparam logic [1:0] PROT_IDX = 2'h0;
  localparam logic [1:0] CTRL_IDX = 2'h1;
  localparam logic [1:0] STOPCTL_IDX = 2'h2;
  localparam logic [1:0] STAT_IDX = 2'h3;
  localparam int ADDR_W = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] PROT_RESET = 8'h00;
  localparam logic [7:0] STOPCTL_RESET = 8'h03;
  localparam int RUN_MODE_SELECT_LSB = 5;
  localparam int ABORT_BIT = 3;
  localparam int STOP_MODE_SELECT_LSB = 0;
  localparam int PROT_VLP_BIT = 5;
  localparam int PROT_LLS_BIT = 3;
  localparam int PROT_VLLS_BIT = 1;
  localparam logic [7:0] PROT_WMASK = 8'h2A;
  localparam logic [7:0] STOPCTL_WMASK = 8'hE7;
  localparam logic [1:0] RUN_NORMAL = 2'h0;
  localparam logic [1:0] RUN_VLP = 2'h2;
  localparam logic [2:0] STOP_NORMAL = 3'h0;
  localparam logic [2:0] STOP_VLP = 3'h2;
  localparam logic [2:0] STOP_LLS = 3'h3;
  localparam logic [2:0] STOP_VLLS = 3'h4;
  localparam logic [6:0] STAT_RUN = 7'h01;
  localparam logic [6:0] STAT_VERY_LOW_POWER_RUN = 7'h04;

  typedef struct packed {
    logic [1:0] run_mode_select;
    logic stop_abort_flag;
    logic [2:0] stop_mode_select;
  } pmc_ctrl_s;

  typedef struct packed {
    logic deep_sleep_request;
    logic stop_entry_start;
    logic stop_entry_abort;
    logic exit_to_normal_run;
  } pmc_core_evt_s;

  typedef struct packed {
    logic [1:0] run_mode;
    logic [2:0] stop_mode;
    logic [2:0] deep_leak_submode;
    logic [1:0] partial_stop;
    logic stop_enter_req;
  } pmc_mode_req_s;
endpackage : pmc_pkg

// file: design/pmc_bus_slave.sv
// Avalon-MM slave front end that registers one access and answers it.
// Assumes the master holds its request until waitrequest is seen low.
`timescale 1ns/1ps
`default_nettype none
module pmc_bus_slave #(
  parameter int ADDR_W = pmc_pkg::ADDR_W
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic [ADDR_W-1:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic supervisor_in,
  output logic waitrequest_out,
  output logic acc_rd_out,
  output logic acc_wr_out,
  output logic [ADDR_W-1:0] acc_addr_out
);
  // The low two address bits select the register, so fewer cannot work.
  if (ADDR_W < 2) begin : g_addr_check
    $error("ADDR_W too small");
  end

  // A one-cycle access pulse; waitrequest drops in the cycle after it.
  logic done_reg;

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= (read_in || write_in) && !done_reg;
    end
  end

  always_comb begin
    waitrequest_out = (read_in || write_in) && !done_reg;
    acc_rd_out = read_in && !done_reg;
    acc_wr_out = write_in && !done_reg && supervisor_in;
    acc_addr_out = address_in;
  end
endmodule : pmc_bus_slave
`default_nettype wire

// file: design/pmc_top.sv
// Power mode control register with its protection, stop control and status.
// Assumes a 32-bit Avalon-MM master and a core that reports stop entry events
// synchronously on clock_in.
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module pmc_top (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic [pmc_pkg::ADDR_W-1:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [31:0] writedata_in,
  input wire logic [3:0] byteenable_in,
  input wire logic supervisor_in,
  input wire pmc_pkg::pmc_core_evt_s core_evt_in,
  input wire logic [6:0] power_mode_status_in,
  output logic waitrequest_out,
  output logic [31:0] readdata_out,
  output logic [1:0] response_out,
  output var pmc_pkg::pmc_mode_req_s mode_req_out
);
  // --------------------------------------------------------------------------
  // Bus front end
  // --------------------------------------------------------------------------
  logic acc_rd;
  logic acc_wr;
  logic [pmc_pkg::ADDR_W-1:0] acc_addr;

  pmc_bus_slave #(.ADDR_W(pmc_pkg::ADDR_W)) u_bus (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .address_in(address_in),
    .read_in(read_in),
    .write_in(write_in),
    .supervisor_in(supervisor_in),
    .waitrequest_out(waitrequest_out),
    .acc_rd_out(acc_rd),
    .acc_wr_out(acc_wr),
    .acc_addr_out(acc_addr)
  );

  function automatic logic hit(input logic [pmc_pkg::ADDR_W-1:0] a, input logic [1:0] idx);
    hit = (a == {{(pmc_pkg::ADDR_W-2){1'b0}}, idx});
  endfunction : hit

  logic mapped;
  logic lane0;
  logic [7:0] wbyte;
  assign mapped = (acc_addr[pmc_pkg::ADDR_W-1:2] == '0);
  assign lane0 = byteenable_in[0];
  assign wbyte = writedata_in[7:0];

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  pmc_pkg::pmc_ctrl_s ctrl_reg;
  logic [7:0] prot_reg;
  logic prot_written_reg;
  logic [7:0] stopctl_reg;
  logic [1:0] run_next;
  logic [2:0] stop_next;
  logic prot_wr_ok;
  logic ctrl_wr;

  assign ctrl_wr = acc_wr && hit(acc_addr, pmc_pkg::CTRL_IDX) && lane0;
  assign prot_wr_ok = acc_wr && hit(acc_addr, pmc_pkg::PROT_IDX) && lane0 &&
                      !prot_written_reg;

  // Only one write after reset reaches the protection register.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prot_reg <= pmc_pkg::PROT_RESET;
      prot_written_reg <= 1'b0;
    end else if (prot_wr_ok) begin
      prot_reg <= wbyte & pmc_pkg::PROT_WMASK;
      prot_written_reg <= 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      stopctl_reg <= pmc_pkg::STOPCTL_RESET;
    end else if (acc_wr && hit(acc_addr, pmc_pkg::STOPCTL_IDX) && lane0) begin
      stopctl_reg <= wbyte & pmc_pkg::STOPCTL_WMASK;
    end
  end

  // Run mode write: accepted only when allowed and a defined code.
  always_comb begin
    run_next = ctrl_reg.run_mode_select;
    if (ctrl_wr) begin
      if (wbyte[pmc_pkg::RUN_MODE_SELECT_LSB +: 2] == pmc_pkg::RUN_NORMAL) begin
        run_next = pmc_pkg::RUN_NORMAL;
      end else if (wbyte[pmc_pkg::RUN_MODE_SELECT_LSB +: 2] == pmc_pkg::RUN_VLP &&
                   prot_reg[pmc_pkg::PROT_VLP_BIT]) begin
        run_next = pmc_pkg::RUN_VLP;
      end
    end
    if (core_evt_in.exit_to_normal_run) begin
      run_next = pmc_pkg::RUN_NORMAL;
    end
  end

  // A refused code leaves the field as it was, so the current mode stays.
  function automatic logic stop_allowed(input logic [2:0] code, input logic [7:0] prot);
    unique case (code)
      pmc_pkg::STOP_NORMAL: stop_allowed = 1'b1;
      pmc_pkg::STOP_VLP: stop_allowed = prot[pmc_pkg::PROT_VLP_BIT];
      pmc_pkg::STOP_LLS: stop_allowed = prot[pmc_pkg::PROT_LLS_BIT];
      pmc_pkg::STOP_VLLS: stop_allowed = prot[pmc_pkg::PROT_VLLS_BIT];
      default: stop_allowed = 1'b0;
    endcase
  endfunction : stop_allowed

  always_comb begin
    stop_next = ctrl_reg.stop_mode_select;
    if (ctrl_wr && stop_allowed(wbyte[pmc_pkg::STOP_MODE_SELECT_LSB +: 3], prot_reg)) begin
      stop_next = wbyte[pmc_pkg::STOP_MODE_SELECT_LSB +: 3];
    end
    if (prot_wr_ok) begin
      stop_next = pmc_pkg::STOP_NORMAL;
    end
  end

  // Mode fields reset only by the power-on reset wired to resetn_in.
  // The whole register is kept in one process so that it has a single driver.
  // Abort flag: an abort in the entry-start cycle wins over the clear.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_reg.run_mode_select <= pmc_pkg::CTRL_RESET[pmc_pkg::RUN_MODE_SELECT_LSB +: 2];
      ctrl_reg.stop_mode_select <= pmc_pkg::CTRL_RESET[pmc_pkg::STOP_MODE_SELECT_LSB +: 3];
      ctrl_reg.stop_abort_flag <= pmc_pkg::CTRL_RESET[pmc_pkg::ABORT_BIT];
    end else begin
      ctrl_reg.run_mode_select <= run_next;
      ctrl_reg.stop_mode_select <= stop_next;
      if (core_evt_in.stop_entry_abort) begin
        ctrl_reg.stop_abort_flag <= 1'b1;
      end else if (core_evt_in.stop_entry_start) begin
        ctrl_reg.stop_abort_flag <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read data and response
  // --------------------------------------------------------------------------
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    unique case (acc_addr[1:0])
      pmc_pkg::PROT_IDX: rd_byte = prot_reg;
      pmc_pkg::CTRL_IDX: rd_byte = {1'b0, ctrl_reg.run_mode_select, 1'b0,
                                    ctrl_reg.stop_abort_flag,
                                    ctrl_reg.stop_mode_select};
      pmc_pkg::STOPCTL_IDX: rd_byte = stopctl_reg;
      pmc_pkg::STAT_IDX: rd_byte = {1'b0, power_mode_status_in};
    endcase
  end

  // Both answers are registered so they stand at the edge waitrequest is low.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      readdata_out <= 32'h0000_0000;
      response_out <= 2'h0;
    end else if (acc_rd || write_in && waitrequest_out) begin
      readdata_out <= (acc_rd && mapped) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      if (!mapped) begin
        response_out <= 2'h3;
      end else if (write_in && !supervisor_in) begin
        response_out <= 2'h2;
      end else begin
        response_out <= 2'h0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Mode request to the power controller
  // --------------------------------------------------------------------------
  // Registered modes already passed the protection check, so any request
  // carries an allowed code only.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mode_req_out <= '0;
    end else begin
      mode_req_out.run_mode <= ctrl_reg.run_mode_select;
      mode_req_out.stop_mode <= ctrl_reg.stop_mode_select;
      mode_req_out.deep_leak_submode <=
        (ctrl_reg.stop_mode_select == pmc_pkg::STOP_VLLS) ? stopctl_reg[2:0] : 3'h0;
      mode_req_out.partial_stop <=
        (ctrl_reg.stop_mode_select == pmc_pkg::STOP_NORMAL) ? stopctl_reg[7:6] : 2'h0;
      mode_req_out.stop_enter_req <= core_evt_in.deep_sleep_request;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  sequence s_ctrl_write(logic [1:0] code);
    ctrl_wr && !core_evt_in.exit_to_normal_run &&
      wbyte[pmc_pkg::RUN_MODE_SELECT_LSB +: 2] == code;
  endsequence

  AST_VLP_BLOCKED: assert property (@(posedge clock_in) disable iff (!resetn_in)
    s_ctrl_write(pmc_pkg::RUN_VLP) and !prot_reg[pmc_pkg::PROT_VLP_BIT] |=>
      ctrl_reg.run_mode_select == $past(ctrl_reg.run_mode_select))
    else $error("run mode changed without protection");
  AST_VLP_TAKEN: assert property (@(posedge clock_in) disable iff (!resetn_in)
    s_ctrl_write(pmc_pkg::RUN_VLP) and prot_reg[pmc_pkg::PROT_VLP_BIT] |=>
      ctrl_reg.run_mode_select == pmc_pkg::RUN_VLP)
    else $error("allowed run mode write lost");
  AST_EXIT_CLEARS: assert property (@(posedge clock_in) disable iff (!resetn_in)
    core_evt_in.exit_to_normal_run |=> ctrl_reg.run_mode_select == pmc_pkg::RUN_NORMAL)
    else $error("run mode not cleared on exit");
  AST_RESERVED_RUN: assert property (@(posedge clock_in) disable iff (!resetn_in)
    ctrl_reg.run_mode_select != 2'h1 && ctrl_reg.run_mode_select != 2'h3)
    else $error("reserved run code stored");
  AST_ABORT_SET: assert property (@(posedge clock_in) disable iff (!resetn_in)
    core_evt_in.stop_entry_abort |=> ctrl_reg.stop_abort_flag)
    else $error("abort flag not set");
  AST_ABORT_CLR: assert property (@(posedge clock_in) disable iff (!resetn_in)
    core_evt_in.stop_entry_start && !core_evt_in.stop_entry_abort |=>
      !ctrl_reg.stop_abort_flag)
    else $error("abort flag not cleared");
  AST_PROT_ONCE: assert property (@(posedge clock_in) disable iff (!resetn_in)
    prot_written_reg |=> prot_reg == $past(prot_reg))
    else $error("protection written twice");
  AST_PROT_CLR_STOP: assert property (@(posedge clock_in) disable iff (!resetn_in)
    prot_wr_ok |=> ctrl_reg.stop_mode_select == pmc_pkg::STOP_NORMAL)
    else $error("stop mode not cleared");
  AST_STOP_ALLOWED: assert property (@(posedge clock_in) disable iff (!resetn_in)
    stop_allowed(ctrl_reg.stop_mode_select, prot_reg))
    else $error("disallowed stop mode held");
  AST_USER_ERR: assert property (@(posedge clock_in) disable iff (!resetn_in)
    write_in && waitrequest_out && !supervisor_in && mapped |=> response_out == 2'h2)
    else $error("user write not refused");
  AST_RSVD_BITS: assert property (@(posedge clock_in) disable iff (!resetn_in)
    acc_rd && hit(acc_addr, pmc_pkg::CTRL_IDX) |=> readdata_out[7] == 1'b0 &&
      readdata_out[4] == 1'b0)
    else $error("reserved bit read nonzero");

  // Stop entry request, the stop control fields passed beside it, and the run mode protection.
  sequence s_sleep_req;
    core_evt_in.deep_sleep_request;
  endsequence

  sequence s_stop_is(logic [2:0] code);
    ctrl_reg.stop_mode_select == code;
  endsequence

  AST_ENTER_REQ: assert property (@(posedge clock_in) disable iff (!resetn_in)
    s_sleep_req |=> mode_req_out.stop_enter_req)
    else $error("stop entry request lost");
  AST_SUBMODE: assert property (@(posedge clock_in) disable iff (!resetn_in)
    s_stop_is(pmc_pkg::STOP_VLLS) |=>
      mode_req_out.deep_leak_submode == $past(stopctl_reg[2:0]))
    else $error("submode not passed on");
  AST_PSTOP: assert property (@(posedge clock_in) disable iff (!resetn_in)
    s_stop_is(pmc_pkg::STOP_NORMAL) |=>
      mode_req_out.partial_stop == $past(stopctl_reg[7:6]))
    else $error("partial stop option not passed on");
  AST_RUN_ALLOWED: assert property (@(posedge clock_in) disable iff (!resetn_in)
    ctrl_reg.run_mode_select == pmc_pkg::RUN_VLP |-> prot_reg[pmc_pkg::PROT_VLP_BIT])
    else $error("run mode held without protection");

  // Unmapped indices answer with a decode error and zero data.
  AST_DECODE_ERR: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (read_in || write_in) && waitrequest_out && !mapped |=>
      response_out == 2'h3 && readdata_out == 32'h0000_0000)
    else $error("unmapped access not refused");
  // Exactly one wait cycle per access keeps the master's wait bounded.
  AST_ONE_WAIT: assert property (@(posedge clock_in) disable iff (!resetn_in)
    (read_in || write_in) && waitrequest_out |=> !waitrequest_out)
    else $error("waitrequest held too long");
endmodule : pmc_top
`default_nettype wire

// file: tb/pmc_core_model.sv
// Core-side model that raises deep sleep and reports stop entry events.
// Assumes commands from the bench arrive synchronously on clock_in.
`timescale 1ns/1ps
`default_nettype none
module pmc_core_model (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic cmd_valid_in,
  input wire logic [1:0] cmd_in,
  output var pmc_pkg::pmc_core_evt_s core_evt_out
);
  // ---------------------------------------------------------------------
  // Event pulses and the deep sleep level
  // ---------------------------------------------------------------------
  // Deep sleep is a level held through the entry and dropped on abort or exit.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      core_evt_out <= '0;
    end else begin
      core_evt_out.stop_entry_start <= cmd_valid_in && (cmd_in == 2'h1);
      core_evt_out.stop_entry_abort <= cmd_valid_in && (cmd_in == 2'h2);
      core_evt_out.exit_to_normal_run <= cmd_valid_in && (cmd_in == 2'h3);
      if (cmd_valid_in) begin
        core_evt_out.deep_sleep_request <= (cmd_in == 2'h1);
      end
    end
  end
endmodule : pmc_core_model
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the power mode control register block.
// Assumes pmc_pkg and pmc_top are compiled first; one 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [3:0] address_in = 4'h0;
  logic read_in = 1'b0;
  logic write_in = 1'b0;
  logic [31:0] writedata_in = 32'h0000_0000;
  logic [3:0] byteenable_in = 4'h0;
  logic supervisor_in = 1'b1;
  logic [6:0] power_mode_status_in = pmc_pkg::STAT_RUN;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd = 2'h0;
  logic waitrequest_out;
  logic [31:0] readdata_out;
  logic [1:0] response_out;
  pmc_pkg::pmc_core_evt_s core_evt;
  pmc_pkg::pmc_mode_req_s mode_req_out;
  int fail_count = 0;
  int checked = 0;
  logic [7:0] q;
  logic [1:0] r;

  pmc_top i_dut (.clock_in(clock_in), .resetn_in(resetn_in), .address_in(address_in),
    .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
    .byteenable_in(byteenable_in), .supervisor_in(supervisor_in), .core_evt_in(core_evt),
    .power_mode_status_in(power_mode_status_in), .waitrequest_out(waitrequest_out),
    .readdata_out(readdata_out), .response_out(response_out), .mode_req_out(mode_req_out));
  pmc_core_model i_core (.clock_in(clock_in), .resetn_in(resetn_in), .cmd_valid_in(cmd_valid),
    .cmd_in(cmd), .core_evt_out(core_evt));

  initial begin
    forever #5 clock_in = ~clock_in;
  end

  // ---------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // The request is held until waitrequest is sampled low, then released.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                     input logic sup);
    address_in <= a;
    writedata_in <= {24'h00_0000, d};
    byteenable_in <= 4'hF;
    supervisor_in <= sup;
    write_in <= wr;
    read_in <= ~wr;
    forever begin
      @(posedge clock_in);
      if (waitrequest_out === 1'b0) break;
    end
    q = readdata_out[7:0];
    r = response_out;
    write_in <= 1'b0;
    read_in <= 1'b0;
    @(posedge clock_in);
  endtask : bus

  task automatic evt(input logic [1:0] c);
    cmd_valid <= 1'b1;
    cmd <= c;
    @(posedge clock_in);
    cmd_valid <= 1'b0;
    repeat (3) @(posedge clock_in);
  endtask : evt

  task automatic do_reset();
    resetn_in <= 1'b0;
    repeat (6) @(posedge clock_in);
    resetn_in <= 1'b1;
    @(posedge clock_in);
  endtask : do_reset

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic t_reset_values();
    bus(1'b0, 4'h0, 8'h00, 1'b1); chk("prot reset", 8'h00, q);
    bus(1'b0, 4'h1, 8'h00, 1'b1); chk("ctrl reset", 8'h00, q);
    bus(1'b0, 4'h2, 8'h00, 1'b1); chk("stopctl reset", 8'h03, q);
  endtask : t_reset_values

  // Without protection only the normal codes may land; reserved bits stay zero.
  task automatic t_guard();
    bus(1'b1, 4'h1, 8'h4A, 1'b0); chk("user wr resp", 8'h02, {6'h00, r});
    bus(1'b1, 4'h1, 8'h42, 1'b1);
    bus(1'b0, 4'h1, 8'h00, 1'b1); chk("blocked ctrl", 8'h00, q);
    chk("blocked run req", 8'h00, {6'h00, mode_req_out.run_mode});
    bus(1'b1, 4'h1, 8'h98, 1'b1);
    bus(1'b0, 4'h1, 8'h00, 1'b1); chk("reserved bits", 8'h00, q);
    bus(1'b0, 4'h4, 8'h00, 1'b1); chk("unmapped resp", 8'h03, {6'h00, r});
  endtask : t_guard

  task automatic t_prot_once();
    bus(1'b1, 4'h0, 8'h2A, 1'b1); chk("prot wr resp", 8'h00, {6'h00, r});
    bus(1'b0, 4'h0, 8'h00, 1'b1); chk("prot first", 8'h2A, q);
    bus(1'b1, 4'h0, 8'h00, 1'b1);
    bus(1'b0, 4'h0, 8'h00, 1'b1); chk("prot second", 8'h2A, q);
  endtask : t_prot_once

  // Reserved stop codes must leave the previous valid code in place.
  task automatic t_modes();
    logic [2:0] codes [8] = '{3'h0, 3'h2, 3'h3, 3'h1, 3'h5, 3'h6, 3'h7, 3'h4};
    logic [2:0] last;
    last = 3'h0;
    power_mode_status_in <= pmc_pkg::STAT_RUN;
    for (int i = 0; i < 8; i++) begin
      if (codes[i] <= 3'h4 && codes[i] != 3'h1) last = codes[i];
      bus(1'b1, 4'h1, {5'h08, codes[i]}, 1'b1);
      bus(1'b0, 4'h1, 8'h00, 1'b1); chk("ctrl code", {5'h08, last}, q);
      chk("stop req", {5'h00, last}, {5'h00, mode_req_out.stop_mode});
      chk("run req", 8'h02, {6'h00, mode_req_out.run_mode});
    end
  endtask : t_modes

  task automatic t_submodes();
    bus(1'b1, 4'h2, 8'h81, 1'b1);
    bus(1'b0, 4'h2, 8'h00, 1'b1); chk("stopctl", 8'h81, q);
    chk("submode", 8'h01, {5'h00, mode_req_out.deep_leak_submode});
    bus(1'b1, 4'h1, 8'h40, 1'b1);
    bus(1'b0, 4'h1, 8'h00, 1'b1); chk("ctrl normal stop", 8'h40, q);
    chk("partial", 8'h02, {6'h00, mode_req_out.partial_stop});
  endtask : t_submodes

  task automatic t_abort();
    evt(2'h1);
    bus(1'b0, 4'h1, 8'h00, 1'b1); chk("flag at start", 8'h40, q);
    chk("enter req", 8'h01, {7'h00, mode_req_out.stop_enter_req});
    evt(2'h2);
    bus(1'b0, 4'h1, 8'h00, 1'b1); chk("flag abort", 8'h48, q);
    chk("enter req drop", 8'h00, {7'h00, mode_req_out.stop_enter_req});
    bus(1'b1, 4'h1, 8'h40, 1'b1);
    bus(1'b0, 4'h1, 8'h00, 1'b1); chk("flag reread", 8'h48, q);
    evt(2'h1);
    bus(1'b0, 4'h1, 8'h00, 1'b1); chk("flag restart", 8'h40, q);
  endtask : t_abort

  task automatic t_exit();
    power_mode_status_in <= pmc_pkg::STAT_VERY_LOW_POWER_RUN;
    evt(2'h3);
    bus(1'b0, 4'h1, 8'h00, 1'b1); chk("run after exit", 8'h00, q);
    bus(1'b0, 4'h3, 8'h00, 1'b1); chk("status", {1'b0, pmc_pkg::STAT_VERY_LOW_POWER_RUN}, q);
    do_reset();
    bus(1'b0, 4'h0, 8'h00, 1'b1); chk("prot rereset", 8'h00, q);
    bus(1'b0, 4'h1, 8'h00, 1'b1); chk("ctrl rereset", 8'h00, q);
  endtask : t_exit

  initial begin
    #200000;
    fail_count++;
    test_done();
  end

  initial begin
    do_reset();
    t_reset_values();
    t_guard();
    t_prot_once();
    t_modes();
    t_submodes();
    t_abort();
    t_exit();
    test_done();
  end
endmodule : testbench
`default_nettype wire
